// ===== design/pio_defs.svh
// constants for the three-port parallel i/o section
// Summary of operation
// - two byte ports and one six-bit port
// - each byte port is input or output only
// - handshake modes take bits 0-2 of six-bit port from general use, or all six with both ports strobed
// - registers decoded at i/o addresses 00 to 03
// - eight command latches, low four set modes
// - bits 4 and 5 enable strobe interrupts
// - bits 6 and 7 form timer command
// - command write at 00 accepted anytime
// - status bits 0-5 ports, bit 6 timer
// - status read at 00 allowed anytime
// - command bit 0 sets first port direction
// - command bit 1 sets second port direction
// - byte ports basic or strobed per alternate mode
// - command bits 2-3 pick four alternate modes
// - third mode: bits 0-2 first port handshake
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH
`define PIO_ADDR_CMD      2'h0
`define PIO_ADDR_PA       2'h1
`define PIO_ADDR_PB       2'h2
`define PIO_ADDR_PC       2'h3
`define PIO_CMD_RESET     8'h00
`define PIO_CMD_PA_DIR    0
`define PIO_CMD_PB_DIR    1
`define PIO_CMD_ALT_LO    2
`define PIO_CMD_IEN_A     4
`define PIO_CMD_IEN_B     5
`define PIO_CMD_TMR_LO    6
`define PIO_ST_INTR_A     0
`define PIO_ST_FULL_A     1
`define PIO_ST_IEN_A      2
`define PIO_ST_INTR_B     3
`define PIO_ST_FULL_B     4
`define PIO_ST_IEN_B      5
`define PIO_ST_TIMER      6
`endif

// ===== design/pio_pkg.sv
// types shared by the parallel i/o section
`default_nettype none
package pio_pkg;
   // alternate port mode of the six-bit port
   typedef enum logic [1:0] {
      PIO_ALT_IN  = 2'h0,
      PIO_ALT_OUT = 2'h1,
      PIO_ALT_HSA = 2'h2,
      PIO_ALT_HSB = 2'h3
   } pio_alt_t;
   // handshake channel state, one-hot
   typedef enum logic [1:0] {
      PIO_HS_IDLE = 2'b01,
      PIO_HS_FULL = 2'b10
   } pio_hs_t;
endpackage : pio_pkg
`default_nettype wire

// ===== design/pio_sync.sv
// two-flop synchroniser for a group of pin inputs
`default_nettype none
module pio_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         i_sys_clk,
   input  wire logic         i_sys_rst,
   // pins and synced copy
   input  wire logic [W-1:0] i_pin,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   // first stage feeds only the second
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= i_pin;
         sync_r <= meta_r;
      end
   end
   assign o_sync = sync_r;
endmodule : pio_sync
`default_nettype wire

// ===== design/pio_hs.sv
// strobe handshake channel for one byte-wide port
`default_nettype none
module pio_hs
   import pio_pkg::*;
(
   // clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_sys_rst,
   // control
   input  wire logic i_active,
   input  wire logic i_is_out,
   input  wire logic i_ien,
   input  wire logic i_strobe_n,
   input  wire logic i_cpu_acc,
   input  wire logic i_cpu_wr,
   // status
   output logic      o_full,
   output logic      o_intr
);
   pio_hs_t st_r, st_nxt;
   logic    intr_r, intr_nxt;
   logic    stb_d_r, stb_d_nxt;
   logic    stb_rise;
   assign stb_rise = i_strobe_n & ~stb_d_r;
   // input: strobe fills, cpu read empties; output: cpu write fills, strobe empties
   always_comb begin
      st_nxt    = st_r;
      intr_nxt  = intr_r;
      stb_d_nxt = i_strobe_n;
      if (!i_active) begin
         st_nxt   = PIO_HS_IDLE;
         intr_nxt = 1'b0;
      end else if (i_is_out) begin
         // a strobe landing with the write still raises its interrupt; the write refills
         if (i_cpu_acc && i_cpu_wr) begin
            st_nxt   = PIO_HS_FULL;
            intr_nxt = stb_rise & i_ien;
         end else if (stb_rise) begin
            st_nxt   = PIO_HS_IDLE;
            intr_nxt = i_ien;
         end
      end else begin
         // a strobe landing with the read wins over the clear
         if (stb_rise) begin
            st_nxt   = PIO_HS_FULL;
            intr_nxt = i_ien;
         end else if (i_cpu_acc && !i_cpu_wr) begin
            st_nxt   = PIO_HS_IDLE;
            intr_nxt = 1'b0;
         end
      end
      if (!i_ien) begin
         intr_nxt = 1'b0;
      end
   end
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st_r    <= PIO_HS_IDLE;
         intr_r  <= 1'b0;
         stb_d_r <= 1'b1;
      end else begin
         st_r    <= st_nxt;
         intr_r  <= intr_nxt;
         stb_d_r <= stb_d_nxt;
      end
   end
   assign o_full = (st_r == PIO_HS_FULL);
   assign o_intr = intr_r;
endmodule : pio_hs
`default_nettype wire

// ===== design/pio_port_section.sv
// three-port parallel i/o section with command and status registers
`include "pio_defs.svh"
`default_nettype none
module pio_port_section
   import pio_pkg::*;
(
   // clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_sys_rst,
   // cpu i/o access, one-cycle strobes
   input  wire logic [1:0] i_io_addr,
   input  wire logic       i_io_wr,
   input  wire logic       i_io_rd,
   input  wire logic [7:0] i_io_wdata,
   output logic      [7:0] o_io_rdata,
   output logic            o_io_rvalid,
   // first byte port pins
   input  wire logic [7:0] i_pa_pin,
   output logic      [7:0] o_pa_pin,
   output logic            o_pa_oe_n,
   // second byte port pins
   input  wire logic [7:0] i_pb_pin,
   output logic      [7:0] o_pb_pin,
   output logic            o_pb_oe_n,
   // six-bit port pins, per-bit enables
   input  wire logic [5:0] i_pc_pin,
   output logic      [5:0] o_pc_pin,
   output logic      [5:0] o_pc_oe_n,
   // timer side
   input  wire logic       i_timer_status,
   output logic      [1:0] o_timer_cmd
);
   ////////////////////////////////////////////////////////////////////////////
   // synchronised pins
   logic [7:0] pa_s;
   logic [7:0] pb_s;
   logic [5:0] pc_s;
   logic       tmr_s;
   pio_sync #(.W(8)) u_sync_a (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .i_pin     (i_pa_pin),
      .o_sync    (pa_s)
   );
   pio_sync #(.W(8)) u_sync_b (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .i_pin     (i_pb_pin),
      .o_sync    (pb_s)
   );
   pio_sync #(.W(7)) u_sync_c (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .i_pin     ({i_timer_status, i_pc_pin}),
      .o_sync    ({tmr_s, pc_s})
   );
   ////////////////////////////////////////////////////////////////////////////
   // command register and data latches
   logic [7:0] cmd_r, cmd_nxt;
   logic [7:0] pa_out_r, pa_out_nxt;
   logic [7:0] pb_out_r, pb_out_nxt;
   logic [5:0] pc_out_r, pc_out_nxt;
   logic [7:0] pa_in_r, pa_in_nxt;
   logic [7:0] pb_in_r, pb_in_nxt;
   pio_alt_t   alt_mode;
   logic       pa_is_out;
   logic       pb_is_out;
   logic       hs_a_on;
   logic       hs_b_on;
   assign pa_is_out = cmd_r[`PIO_CMD_PA_DIR];
   assign pb_is_out = cmd_r[`PIO_CMD_PB_DIR];
   assign alt_mode  = pio_alt_t'(cmd_r[`PIO_CMD_ALT_LO +: 2]);
   // strobed mode for a byte port follows the six-bit port mode
   assign hs_a_on = (alt_mode == PIO_ALT_HSA) || (alt_mode == PIO_ALT_HSB);
   assign hs_b_on = (alt_mode == PIO_ALT_HSB);
   // strobe pins per port
   logic stb_a_n;
   logic stb_b_n;
   assign stb_a_n = hs_a_on ? pc_s[2] : 1'b1;
   assign stb_b_n = hs_b_on ? pc_s[5] : 1'b1;
   // cpu access qualified per port data register
   logic acc_a;
   logic acc_b;
   assign acc_a = (i_io_wr || i_io_rd) && (i_io_addr == `PIO_ADDR_PA);
   assign acc_b = (i_io_wr || i_io_rd) && (i_io_addr == `PIO_ADDR_PB);
   logic full_a, intr_a, full_b, intr_b;
   pio_hs u_hs_a (
      .i_sys_clk  (i_sys_clk),
      .i_sys_rst  (i_sys_rst),
      .i_active   (hs_a_on),
      .i_is_out   (pa_is_out),
      .i_ien      (cmd_r[`PIO_CMD_IEN_A]),
      .i_strobe_n (stb_a_n),
      .i_cpu_acc  (acc_a),
      .i_cpu_wr   (i_io_wr),
      .o_full     (full_a),
      .o_intr     (intr_a)
   );
   pio_hs u_hs_b (
      .i_sys_clk  (i_sys_clk),
      .i_sys_rst  (i_sys_rst),
      .i_active   (hs_b_on),
      .i_is_out   (pb_is_out),
      .i_ien      (cmd_r[`PIO_CMD_IEN_B]),
      .i_strobe_n (stb_b_n),
      .i_cpu_acc  (acc_b),
      .i_cpu_wr   (i_io_wr),
      .o_full     (full_b),
      .o_intr     (intr_b)
   );
   // register writes and input capture; strobed inputs latch on strobe low
   always_comb begin
      cmd_nxt    = cmd_r;
      pa_out_nxt = pa_out_r;
      pb_out_nxt = pb_out_r;
      pc_out_nxt = pc_out_r;
      pa_in_nxt  = (hs_a_on && stb_a_n) ? pa_in_r : pa_s;
      pb_in_nxt  = (hs_b_on && stb_b_n) ? pb_in_r : pb_s;
      if (i_io_wr) begin
         unique case (i_io_addr)
            `PIO_ADDR_CMD: cmd_nxt    = i_io_wdata;
            `PIO_ADDR_PA:  pa_out_nxt = i_io_wdata;
            `PIO_ADDR_PB:  pb_out_nxt = i_io_wdata;
            `PIO_ADDR_PC:  pc_out_nxt = i_io_wdata[5:0];
         endcase
      end
   end
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cmd_r    <= `PIO_CMD_RESET;
         pa_out_r <= 8'h00;
         pb_out_r <= 8'h00;
         pc_out_r <= 6'h00;
         pa_in_r  <= 8'h00;
         pb_in_r  <= 8'h00;
      end else begin
         cmd_r    <= cmd_nxt;
         pa_out_r <= pa_out_nxt;
         pb_out_r <= pb_out_nxt;
         pc_out_r <= pc_out_nxt;
         pa_in_r  <= pa_in_nxt;
         pb_in_r  <= pb_in_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // status word
   logic [6:0] status;
   always_comb begin
      status                  = 7'h00;
      status[`PIO_ST_INTR_A]  = intr_a;
      status[`PIO_ST_FULL_A]  = full_a;
      status[`PIO_ST_IEN_A]   = cmd_r[`PIO_CMD_IEN_A];
      status[`PIO_ST_INTR_B]  = intr_b;
      status[`PIO_ST_FULL_B]  = full_b;
      status[`PIO_ST_IEN_B]   = cmd_r[`PIO_CMD_IEN_B];
      status[`PIO_ST_TIMER]   = tmr_s;
   end
   ////////////////////////////////////////////////////////////////////////////
   // six-bit port pin map per alternate mode
   logic [5:0] pc_drv, pc_oe_n, pc_rd;
   always_comb begin
      pc_drv  = pc_out_r;
      pc_oe_n = 6'h3f;
      pc_rd   = pc_s;
      unique case (alt_mode)
         PIO_ALT_IN: begin
            pc_oe_n = 6'h3f;
         end
         PIO_ALT_OUT: begin
            pc_oe_n = 6'h00;
            pc_rd   = pc_out_r;
         end
         PIO_ALT_HSA: begin
            // bits 3-5 stay plain outputs for the board options
            pc_drv  = {pc_out_r[5:3], 1'b1, ~full_a, intr_a};
            pc_oe_n = 6'h04;
            pc_rd   = {pc_out_r[5:3], pc_s[2], full_a, intr_a};
         end
         PIO_ALT_HSB: begin
            pc_drv  = {1'b1, ~full_b, intr_b, 1'b1, ~full_a, intr_a};
            pc_oe_n = 6'h24;
            pc_rd   = {pc_s[5], full_b, intr_b, pc_s[2], full_a, intr_a};
         end
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////
   // read data mux; port-c writes with both ports strobed only update the latch
   logic [7:0] rd_nxt;
   always_comb begin
      rd_nxt = 8'h00;
      unique case (i_io_addr)
         `PIO_ADDR_CMD: rd_nxt = {1'b0, status};
         `PIO_ADDR_PA:  rd_nxt = pa_is_out ? pa_out_r : pa_in_r;
         `PIO_ADDR_PB:  rd_nxt = pb_is_out ? pb_out_r : pb_in_r;
         `PIO_ADDR_PC:  rd_nxt = {2'h0, pc_rd};
      endcase
   end
   // registered outputs
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_io_rdata  <= 8'h00;
         o_io_rvalid <= 1'b0;
         o_pa_pin    <= 8'h00;
         o_pa_oe_n   <= 1'b1;
         o_pb_pin    <= 8'h00;
         o_pb_oe_n   <= 1'b1;
         o_pc_pin    <= 6'h00;
         o_pc_oe_n   <= 6'h3f;
         o_timer_cmd <= 2'h0;
      end else begin
         o_io_rdata  <= i_io_rd ? rd_nxt : 8'h00;
         o_io_rvalid <= i_io_rd;
         o_pa_pin    <= pa_out_r;
         o_pa_oe_n   <= ~pa_is_out;
         o_pb_pin    <= pb_out_r;
         o_pb_oe_n   <= ~pb_is_out;
         o_pc_pin    <= pc_drv;
         o_pc_oe_n   <= pc_oe_n;
         o_timer_cmd <= cmd_r[`PIO_CMD_TMR_LO +: 2];
      end
   end
endmodule : pio_port_section
`default_nettype wire

// ===== dv/pio_properties.sv
// port assertions for the parallel i/o section
`default_nettype none
module pio_chk (
   // clock, reset and cpu access
   input wire logic       i_sys_clk,
   input wire logic       i_sys_rst,
   input wire logic [1:0] i_io_addr,
   input wire logic       i_io_wr,
   input wire logic       i_io_rd,
   input wire logic [7:0] i_io_wdata,
   input wire logic [7:0] o_io_rdata,
   input wire logic       o_io_rvalid,
   // pin drive and timer command
   input wire logic [7:0] o_pa_pin,
   input wire logic       o_pa_oe_n,
   input wire logic [5:0] o_pc_pin,
   input wire logic [5:0] o_pc_oe_n,
   input wire logic [1:0] o_timer_cmd
);
   // six-bit enables for alternate modes 3..0, low = driving
   localparam logic [23:0] PC_OE = {6'h24, 6'h04, 6'h00, 6'h3f};
   wire logic cw = i_io_wr && i_io_addr == 2'h0;
   wire logic aw = i_io_wr && i_io_addr == 2'h1 && !o_pa_oe_n;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   ////////////////////////////////////////////////////////////
   // a write left alone for a cycle has reached the pins two edges on
   sequence cmd_s;
      cw ##1 !cw;
   endsequence
   rd_answer_a: assert property (i_io_rd |=> o_io_rvalid)
      else $error("read not answered");
   rvalid_cause_a: assert property (o_io_rvalid |-> $past(i_io_rd))
      else $error("read valid without read");
   rdata_idle_a: assert property (!o_io_rvalid |-> o_io_rdata == 8'h00)
      else $error("read data not cleared");
   status_top_a: assert property (
      o_io_rvalid && $past(i_io_addr) == 2'h0 |-> !o_io_rdata[7]) else $error("status bit 7");
   pc_top_a: assert property (
      o_io_rvalid && $past(i_io_addr) == 2'h3 |-> o_io_rdata[7:6] == 2'h0) else $error("pc top");
   timer_cmd_a: assert property (
      cmd_s |=> o_timer_cmd == $past(i_io_wdata[7:6], 2)) else $error("timer command");
   pa_dir_a: assert property (
      cmd_s |=> o_pa_oe_n == !$past(i_io_wdata[0], 2)) else $error("first port direction");
   pc_mode_a: assert property (
      cmd_s |=> o_pc_oe_n == PC_OE[6 * int'($past(i_io_wdata[3:2], 2)) +: 6])
      else $error("six-bit enables");
   pa_data_a: assert property (
      aw ##1 !aw |=> o_pa_pin == $past(i_io_wdata, 2)) else $error("first port data");
   cover property (o_io_rvalid && $past(i_io_addr) == 2'h0);
   cover property (!o_pc_oe_n[1] && !o_pc_pin[1]);
   cover property (!o_pc_oe_n[3] && $rose(o_pc_pin[3]));
endmodule : pio_chk
bind pio_port_section pio_chk u_chk (.i_sys_clk, .i_sys_rst, .i_io_addr, .i_io_wr, .i_io_rd,
   .i_io_wdata, .o_io_rdata, .o_io_rvalid, .o_pa_pin, .o_pa_oe_n, .o_pc_pin, .o_pc_oe_n,
   .o_timer_cmd);
`default_nettype wire

// ===== dv/pio_periph.sv
// peripheral model on the far side of the three port pin groups
`default_nettype none
module pio_periph (
   // clock and bench commands
   input  wire logic       i_sys_clk,
   input  wire logic       i_go_a,
   input  wire logic       i_go_b,
   input  wire logic       i_slow,
   input  wire logic [7:0] i_byte_a,
   input  wire logic [7:0] i_byte_b,
   input  wire logic [5:0] i_byte_c,
   // design pin drive
   input  wire logic [7:0] i_pa_pin,
   input  wire logic       i_pa_oe_n,
   input  wire logic [7:0] i_pb_pin,
   input  wire logic       i_pb_oe_n,
   input  wire logic [5:0] i_pc_pin,
   input  wire logic [5:0] i_pc_oe_n,
   // resolved line levels
   output logic      [7:0] o_wire_a,
   output logic      [7:0] o_wire_b,
   output logic      [5:0] o_wire_c
);
   logic [3:0] cnt_a = 4'h0;
   logic [3:0] cnt_b = 4'h0;
   ////////////////////////////////////////////////////////////
   // strobe low 2 cycles, or 7 when slow, so both timings reach the synchroniser
   always @(posedge i_sys_clk) begin
      cnt_a <= i_go_a ? (i_slow ? 4'h7 : 4'h2) : cnt_a - 4'(cnt_a != 4'h0);
      cnt_b <= i_go_b ? (i_slow ? 4'h7 : 4'h2) : cnt_b - 4'(cnt_b != 4'h0);
   end
   ////////////////////////////////////////////////////////////
   // the design owns a line only where its enable is low; strobes idle high
   always_comb begin
      o_wire_a = i_pa_oe_n ? i_byte_a : i_pa_pin;
      o_wire_b = i_pb_oe_n ? i_byte_b : i_pb_pin;
      for (int k = 0; k < 6; k++) o_wire_c[k] = i_pc_oe_n[k] ? i_byte_c[k] : i_pc_pin[k];
      if (!i_pc_oe_n[1] && i_pc_oe_n[2]) o_wire_c[2] = (cnt_a == 4'h0);
      if (!i_pc_oe_n[4] && i_pc_oe_n[5]) o_wire_c[5] = (cnt_b == 4'h0);
   end
endmodule : pio_periph
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the parallel i/o section
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tst = 1'b0;
   logic        ga = 1'b0, gb = 1'b0, slow = 1'b0, rv, pa_oe, pb_oe;
   logic [1:0]  addr = 2'h0, tcmd;
   logic [7:0]  wd = 8'h00, ba = 8'h00, bb = 8'h00, rdat, pa, pb, wa, wb;
   logic [5:0]  bc = 6'h00, pc, pc_oe, wc;
   logic [31:0] rs = 32'h4926f5f6;
   int          err_total = 0;
   int          samples_checked = 0;
   initial forever #5 clk = ~clk;
   pio_port_section dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_io_addr(addr), .i_io_wr(wr),
      .i_io_rd(rd), .i_io_wdata(wd), .o_io_rdata(rdat), .o_io_rvalid(rv), .i_pa_pin(wa),
      .o_pa_pin(pa), .o_pa_oe_n(pa_oe), .i_pb_pin(wb), .o_pb_pin(pb), .o_pb_oe_n(pb_oe),
      .i_pc_pin(wc), .o_pc_pin(pc), .o_pc_oe_n(pc_oe), .i_timer_status(tst),
      .o_timer_cmd(tcmd));
   pio_periph per (.i_sys_clk(clk), .i_go_a(ga), .i_go_b(gb), .i_slow(slow), .i_byte_a(ba),
      .i_byte_b(bb), .i_byte_c(bc), .i_pa_pin(pa), .i_pa_oe_n(pa_oe), .i_pb_pin(pb),
      .i_pb_oe_n(pb_oe), .i_pc_pin(pc), .i_pc_oe_n(pc_oe), .o_wire_a(wa), .o_wire_b(wb),
      .o_wire_c(wc));
   ////////////////////////////////////////////////////////////
   // random source, repeatable from its fixed start value
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // one-cycle write strobe, launched and dropped on falling edges
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(negedge clk);
      {addr, wd, wr} = {a, d, 1'b1};
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_reg
   // read data stands one cycle, so it is sampled in that cycle only
   task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
      @(negedge clk);
      {addr, rd} = {a, 1'b1};
      @(negedge clk);
      rd = 1'b0;
      `CHK(rv, 1'b1)
      `CHK(rdat, e)
   endtask : rd_reg
   // bounded wait on a six-bit port pin; running out is a failure
   task automatic wait_pin(input int b, input logic v);
      int n;
      for (n = 0; n < 30 && pc[b] !== v; n++) @(negedge clk);
      if (n == 30) begin
         err_total++;
         $display("unexpected at %0t: pin wait ran out", $time);
         end_of_test();
      end
   endtask : wait_pin
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   // strobe pulse request to the peripheral, one cycle wide
   task automatic strobe(input logic b);
      {gb, ga} = {b, !b};
      @(negedge clk);
      {gb, ga} = 2'b00;
   endtask : strobe
   ////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] cmd, d;
      tst = 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      `CHK({pa_oe, pb_oe, pc_oe, tcmd}, 10'h3fc)
      repeat (3) @(negedge clk);
      rd_reg(2'h0, 8'h40);
      // basic modes: random commands, data and pins, corner command first
      for (int i = 0; i < 10; i++) begin
         rs = lfsr(rs);
         cmd = (i == 0) ? 8'hf7 : {rs[7:4], 1'b0, rs[2:0]};
         {ba, bb, bc, tst} = rs[31:9];
         d = ~rs[31:24];
         wr_reg(2'h0, cmd);
         wr_reg(2'h1, d);
         wr_reg(2'h2, ~d);
         wr_reg(2'h3, d);
         repeat (2) @(negedge clk);
         `CHK({pb_oe, pa_oe}, ~cmd[1:0])
         `CHK(tcmd, cmd[7:6])
         `CHK(pc_oe, {6{~cmd[2]}})
         if (cmd[0]) `CHK(pa, d) else rd_reg(2'h1, ba);
         if (cmd[1]) `CHK(pb, ~d) else rd_reg(2'h2, bb);
         if (cmd[2]) `CHK(pc, d[5:0]) else rd_reg(2'h3, {2'h0, bc});
         rd_reg(2'h0, {1'b0, tst, cmd[5], 2'h0, cmd[4], 2'h0});
      end
      // both ports strobed: first as input with a slow strobe, second as output
      // park the six-bit lines idle high first, so entering handshake sees no false edge
      bc = 6'h3f;
      wr_reg(2'h0, 8'h00);
      repeat (3) @(negedge clk);
      wr_reg(2'h0, 8'h3e);
      {ba, slow} = {8'ha5, 1'b1};
      strobe(1'b0);
      wait_pin(1, 1'b0);
      @(negedge clk);
      `CHK(pc[0], 1'b1)
      rd_reg(2'h0, {1'b0, tst, 6'h27});
      rd_reg(2'h1, 8'ha5);
      @(negedge clk);
      `CHK(pc[1:0], 2'h2)
      wr_reg(2'h2, 8'h3c);
      @(negedge clk);
      `CHK({pb, pc[4:3]}, 10'h0f0)
      slow = 1'b0;
      strobe(1'b1);
      wait_pin(4, 1'b1);
      @(negedge clk);
      rd_reg(2'h0, {1'b0, tst, 6'h2c});
      wr_reg(2'h0, 8'h1e);
      repeat (2) @(negedge clk);
      `CHK(pc[3], 1'b0)
      // first port strobed with interrupt off, second in basic input mode
      wr_reg(2'h0, 8'h08);
      ba = 8'h5a;
      strobe(1'b0);
      wait_pin(1, 1'b0);
      wr_reg(2'h3, 8'h3f);
      repeat (3) @(negedge clk);
      `CHK(pc[1:0], 2'h0)
      rd_reg(2'h2, bb);
      rd_reg(2'h1, 8'h5a);
      end_of_test();
   end
endmodule : tb
`undef CHK
`default_nettype wire
